// ---- asbd_top.sv ----
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Characters are 8 or 9 data bits per length select bit.
// - In 9-bit mode transmit ninth bit comes from control three.
// - Data buffer is write-only holding stage before shift register.
// - Transmission starts with all-ones preamble, then loads character.
// - Frame has zero start bit first and one stop bit last.
// - Buffer-empty flag sets when buffer hands byte to shifter.
// - Empty flag with its enable raises transmitter interrupt.
// - Output rests at logic one when not sending.
// - Clearing unit enable releases the transmit pin.
// - Done flag sets only with shifter and buffer empty, no idle.
// - Done flag with its enable raises transmitter interrupt.
// - In 9-bit receive ninth bit lands in control two.
// - In 8-bit receive that field copies bit seven.
// - Divisor select codes 000..111 give divisors 1 to 128.
// - Baud equals source over sixteen times prescale times divisor.
// - Source is bus clock or oscillator per select bit.
module asbd_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic oscillator_clock,
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic tx_irq
);
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] ctrl3_reg;
  logic [7:0] baud_reg;
  logic [7:0] data_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic tempty_reg;
  logic tdone_reg;
  logic rfull_reg;
  logic ferr_reg;
  logic stat_seen_reg;
  logic [8:0] rx_data_reg;
  logic osc_prev_reg;
  asbd_pkg::asbd_txst_t tx_st_reg;
  logic [10:0] tx_sh_reg;
  logic [3:0] tx_bit_reg;
  logic [3:0] tx_ph_reg;
  logic pre_done_reg;
  logic txd_reg;
  logic oe_reg;
  logic irq_reg;
  logic tick16;
  logic [8:0] rx_word;
  logic rx_strobe;
  logic rx_frame_ok;
  asbd_pkg::asbd_cfg_t cfg;

  assign cfg.en = ctrl1_reg[asbd_pkg::C1_ENABLE];
  assign cfg.len9 = ctrl1_reg[asbd_pkg::C1_LEN9];
  assign cfg.tx_on = ctrl2_reg[asbd_pkg::C2_TXON];
  assign cfg.rx_on = ctrl2_reg[asbd_pkg::C2_RXON];
  assign cfg.tx9 = ctrl3_reg[asbd_pkg::C3_TX9];

  // Request seen with waitrequest high, taken at the edge it is low
  wire req = (avs_read || avs_write) && !ack_reg;
  wire rd_seen = avs_read && !ack_reg;
  wire wr = avs_write && ack_reg;
  wire rd = avs_read && ack_reg;
  wire sel_c1 = avs_address == asbd_pkg::ADDR_CTRL1;
  wire sel_c2 = avs_address == asbd_pkg::ADDR_CTRL2;
  wire sel_c3 = avs_address == asbd_pkg::ADDR_CTRL3;
  wire sel_s1 = avs_address == asbd_pkg::ADDR_STAT1;
  wire sel_dt = avs_address == asbd_pkg::ADDR_DATA;
  wire sel_bd = avs_address == asbd_pkg::ADDR_BAUD;
  wire data_wr = wr && sel_dt;
  wire data_rd = rd && sel_dt;
  wire stat_rd = rd && sel_s1;
  // Empty flag cleared by status read then data write
  wire temp_clr = data_wr && stat_seen_reg && tempty_reg;

  wire [7:0] stat_val = {tempty_reg, tdone_reg, rfull_reg, 3'h0,
                         ferr_reg, 1'b0};
  wire [7:0] c2_val = {ctrl2_reg[7:1], rx_data_reg[8]};
  // Data address reads receive data; the transmit buffer is write-only
  wire [7:0] rd_mux = sel_c1 ? ctrl1_reg :
                      sel_c2 ? c2_val :
                      sel_c3 ? ctrl3_reg :
                      sel_s1 ? stat_val :
                      sel_dt ? rx_data_reg[7:0] :
                      sel_bd ? baud_reg : 8'h00;

  // Transmitter control
  wire tx_idle = tx_st_reg == asbd_pkg::ASBD_TX_IDLE;
  wire tx_go = cfg.en && cfg.tx_on;
  wire tx_bit_end = tick16 && (tx_ph_reg == asbd_pkg::OVERSAMPLE);
  wire [3:0] frame_last = cfg.len9 ? asbd_pkg::FRAME_BITS9 :
                                     asbd_pkg::FRAME_BITS8;
  wire shift_done = tx_bit_end && (tx_bit_reg == frame_last - 4'h1);
  // From rest once the preamble is out, else at the end of a frame
  wire load_ready = tx_idle ? pre_done_reg : shift_done;
  wire load_char = tx_go && !tempty_reg && load_ready;
  // Start bit low, ninth bit from control three, stop bit high
  wire [10:0] frame_word = cfg.len9 ?
    {1'b1, cfg.tx9, data_reg, 1'b0} :
    {2'b11, data_reg, 1'b0};
  wire osc_tick = oscillator_clock && !osc_prev_reg;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl1_reg <= asbd_pkg::RESET_CTRL;
      ctrl2_reg <= asbd_pkg::RESET_CTRL;
      ctrl3_reg <= asbd_pkg::RESET_CTRL;
      baud_reg <= asbd_pkg::RESET_BAUD;
      data_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      stat_seen_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= oscillator_clock;
      ack_reg <= req;
      // Read data must already stand when waitrequest drops
      if (rd_seen) begin
        rdata_reg <= {24'h000000, rd_mux};
      end
      if (stat_rd) begin
        stat_seen_reg <= 1'b1;
      end else if (data_wr) begin
        stat_seen_reg <= 1'b0;
      end
      if (wr && sel_c1) begin
        ctrl1_reg <= avs_writedata[7:0];
      end
      if (wr && sel_c2) begin
        ctrl2_reg <= avs_writedata[7:0];
      end
      if (wr && sel_c3) begin
        ctrl3_reg <= avs_writedata[7:0];
      end
      if (wr && sel_bd) begin
        baud_reg <= avs_writedata[7:0];
      end
      if (temp_clr) begin
        data_reg <= avs_writedata[7:0];
      end
    end
  end

  // Status flags; hardware set wins over software clear for empty and full, the data write wins for done
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tempty_reg <= 1'b1;
      tdone_reg <= 1'b1;
      rfull_reg <= 1'b0;
      ferr_reg <= 1'b0;
      rx_data_reg <= 9'h000;
    end else begin
      if (load_char) begin
        tempty_reg <= 1'b1;
      end else if (temp_clr) begin
        tempty_reg <= 1'b0;
      end
      // Not done while a preamble is pending after enable
      if (tx_idle && tempty_reg && !temp_clr &&
          (pre_done_reg || !tx_go)) begin
        tdone_reg <= 1'b1;
      end else begin
        tdone_reg <= 1'b0;
      end
      if (rx_strobe) begin
        rfull_reg <= 1'b1;
        ferr_reg <= !rx_frame_ok;
        rx_data_reg <= rx_word;
      end else if (data_rd) begin
        rfull_reg <= 1'b0;
      end
    end
  end

  // Transmit shifter; one preamble after each enable, then rest or load
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tx_st_reg <= asbd_pkg::ASBD_TX_IDLE;
      tx_sh_reg <= 11'h7FF;
      tx_bit_reg <= 4'h0;
      tx_ph_reg <= 4'h0;
      pre_done_reg <= 1'b0;
    end else if (!tx_go) begin
      tx_st_reg <= asbd_pkg::ASBD_TX_IDLE;
      tx_sh_reg <= 11'h7FF;
      pre_done_reg <= 1'b0;
    end else begin
      if (tick16) begin
        tx_ph_reg <= tx_ph_reg + 4'h1;
      end
      unique case (tx_st_reg)
        asbd_pkg::ASBD_TX_IDLE: begin
          tx_bit_reg <= 4'h0;
          tx_ph_reg <= 4'h0;
          if (!pre_done_reg) begin
            tx_st_reg <= asbd_pkg::ASBD_TX_PRE;
            tx_sh_reg <= 11'h7FF;
          end else if (load_char) begin
            tx_st_reg <= asbd_pkg::ASBD_TX_SHIFT;
            tx_sh_reg <= frame_word;
          end
        end
        asbd_pkg::ASBD_TX_PRE, asbd_pkg::ASBD_TX_SHIFT: begin
          if (shift_done) begin
            pre_done_reg <= 1'b1;
          end
          if (load_char) begin
            tx_st_reg <= asbd_pkg::ASBD_TX_SHIFT;
            tx_sh_reg <= frame_word;
            tx_bit_reg <= 4'h0;
          end else if (shift_done) begin
            tx_st_reg <= asbd_pkg::ASBD_TX_IDLE;
            tx_sh_reg <= 11'h7FF;
          end else if (tx_bit_end) begin
            tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txd_reg <= 1'b1;
      oe_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      txd_reg <= tx_go ? tx_sh_reg[0] : 1'b1;
      oe_reg <= cfg.en;
      irq_reg <= (tempty_reg && ctrl2_reg[asbd_pkg::C2_TEIE]) ||
                 (tdone_reg && ctrl2_reg[asbd_pkg::C2_TX_DONE_IRQ_ENABLE]);
    end
  end

  asbd_baud u_baud (
    .mclk(mclk),
    .reset(reset),
    .osc_tick(osc_tick),
    .clock_source_select(baud_reg[asbd_pkg::BR_CKS]),
    .prescale_divisor(baud_reg[asbd_pkg::BR_PD_LO +: 3]),
    .baud_divisor(baud_reg[asbd_pkg::BR_BD_LO +: 3]),
    .tick16(tick16)
  );

  asbd_rx u_rx (
    .mclk(mclk),
    .reset(reset),
    .enable(cfg.en && cfg.rx_on),
    .len9(cfg.len9),
    .tick16(tick16),
    .rxd(rxd_in),
    .rx_word(rx_word),
    .rx_strobe(rx_strobe),
    .rx_frame_ok(rx_frame_ok)
  );

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = !ack_reg;
  assign txd_out = txd_reg;
  assign txd_oe = oe_reg;
  assign tx_irq = irq_reg;

  chk_irq_from_empty: assert property (@(posedge mclk) disable iff (reset)
    tempty_reg && ctrl2_reg[asbd_pkg::C2_TEIE] |=> tx_irq)
    else $error("empty flag did not raise interrupt");
  chk_idle_line_high: assert property (@(posedge mclk) disable iff (reset)
    !tx_go |=> txd_out)
    else $error("line not idle high");
  chk_pins_released: assert property (@(posedge mclk) disable iff (reset)
    !cfg.en |=> !txd_oe)
    else $error("pin still driven after disable");
  chk_load_sets_empty: assert property (@(posedge mclk) disable iff (reset)
    load_char |=> tempty_reg)
    else $error("empty flag not set on load");
  chk_start_bit_low: assert property (@(posedge mclk) disable iff (reset)
    load_char |=> !tx_sh_reg[0])
    else $error("start bit not low");
  chk_done_needs_idle: assert property (@(posedge mclk) disable iff (reset)
    !tx_idle |=> !tdone_reg)
    else $error("done flag set while shifter busy");
  chk_irq_from_done: assert property (@(posedge mclk) disable iff (reset)
    tdone_reg && ctrl2_reg[asbd_pkg::C2_TX_DONE_IRQ_ENABLE] |=> tx_irq)
    else $error("done flag did not raise interrupt");
  chk_preamble_ones: assert property (@(posedge mclk) disable iff (reset)
    tx_st_reg == asbd_pkg::ASBD_TX_PRE |-> tx_sh_reg == 11'h7FF)
    else $error("preamble not all ones");
  chk_ninth_from_ctrl: assert property (@(posedge mclk) disable iff (reset)
    load_char && cfg.len9 |=> tx_sh_reg[9] == $past(cfg.tx9))
    else $error("ninth bit not from control three");
endmodule // asbd_top

// ---- asbd_pkg.sv ----
package asbd_pkg;
  // Register word offsets on the word-wide bus
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_CTRL2 = 4'h1;
  localparam logic [3:0] ADDR_CTRL3 = 4'h2;
  localparam logic [3:0] ADDR_STAT1 = 4'h3;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_BAUD = 4'h5;
  // Control one fields
  localparam int C1_ENABLE = 6;
  localparam int C1_LEN9 = 4;
  // Control two fields
  localparam int C2_TEIE = 7;
  localparam int C2_TX_DONE_IRQ_ENABLE = 6;
  localparam int C2_TXON = 3;
  localparam int C2_RXON = 2;
  localparam int C2_RX9 = 0;
  // Control three field
  localparam int C3_TX9 = 6;
  // Status one fields
  localparam int S1_TEMPTY = 7;
  localparam int S1_TDONE = 6;
  localparam int S1_RFULL = 5;
  localparam int S1_FERR = 1;
  // Baud register fields
  localparam int BR_CKS = 6;
  localparam int BR_PD_LO = 3;
  localparam int BR_BD_LO = 0;
  localparam logic [7:0] RESET_CTRL = 8'h00;
  localparam logic [7:0] RESET_BAUD = 8'h00;
  localparam logic [3:0] OVERSAMPLE = 4'hF;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [3:0] FRAME_BITS9 = 4'hB;
  localparam logic [3:0] FRAME_BITS8 = 4'hA;
  typedef struct packed {
    logic en;
    logic len9;
    logic tx_on;
    logic rx_on;
    logic tx9;
  } asbd_cfg_t;
  typedef enum logic [1:0] {
    ASBD_TX_IDLE = 2'b00,
    ASBD_TX_PRE = 2'b01,
    ASBD_TX_SHIFT = 2'b10
  } asbd_txst_t;
endpackage

// ---- asbd_baud.sv ----
`timescale 1ns/1ps
// Sixteen-times oversampling tick from selectable source
module asbd_baud (
  input wire logic mclk,
  input wire logic reset,
  input wire logic osc_tick,
  input wire logic clock_source_select,
  input wire logic [2:0] prescale_divisor,
  input wire logic [2:0] baud_divisor,
  output logic tick16
);
  logic [2:0] pd_cnt_reg;
  logic [6:0] bd_cnt_reg;
  logic tick16_reg;
  wire src_tick = clock_source_select ? osc_tick : 1'b1;
  wire pd_wrap = (pd_cnt_reg == prescale_divisor);
  wire [6:0] bd_max = 7'((8'h01 << baud_divisor) - 8'h01);
  wire bd_wrap = (bd_cnt_reg >= bd_max);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pd_cnt_reg <= 3'h0;
      bd_cnt_reg <= 7'h00;
      tick16_reg <= 1'b0;
    end else begin
      tick16_reg <= 1'b0;
      if (src_tick) begin
        pd_cnt_reg <= pd_wrap ? 3'h0 : pd_cnt_reg + 3'h1;
        if (pd_wrap) begin
          bd_cnt_reg <= bd_wrap ? 7'h00 : bd_cnt_reg + 7'h01;
          tick16_reg <= bd_wrap;
        end
      end
    end
  end
  assign tick16 = tick16_reg;
endmodule // asbd_baud

// ---- asbd_rx.sv ----
`timescale 1ns/1ps
// Receiver with start edge detection and mid-bit sampling
module asbd_rx (
  input wire logic mclk,
  input wire logic reset,
  input wire logic enable,
  input wire logic len9,
  input wire logic tick16,
  input wire logic rxd,
  output logic [8:0] rx_word,
  output logic rx_strobe,
  output logic rx_frame_ok
);
  logic busy_reg;
  logic rxd_prev_reg;
  logic [3:0] phase_reg;
  logic [3:0] bit_reg;
  logic [9:0] sh_reg;
  logic [8:0] word_reg;
  logic strobe_reg;
  logic ok_reg;
  wire [3:0] last_bit = len9 ? 4'hA : 4'h9;
  wire start_edge = enable && !busy_reg && rxd_prev_reg && !rxd;
  wire mid = tick16 && (phase_reg == asbd_pkg::SAMPLE_MID);
  wire [9:0] sh_next = {rxd, sh_reg[9:1]};
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_reg <= 1'b0;
      rxd_prev_reg <= 1'b1;
      phase_reg <= 4'h0;
      bit_reg <= 4'h0;
      sh_reg <= 10'h000;
      word_reg <= 9'h000;
      strobe_reg <= 1'b0;
      ok_reg <= 1'b0;
    end else begin
      rxd_prev_reg <= rxd;
      strobe_reg <= 1'b0;
      if (start_edge) begin
        busy_reg <= 1'b1;
        phase_reg <= 4'h0;
        bit_reg <= 4'h0;
      end else if (busy_reg && !enable) begin
        busy_reg <= 1'b0;
      end else if (busy_reg && tick16) begin
        phase_reg <= phase_reg + 4'h1;
        if (mid) begin
          bit_reg <= bit_reg + 4'h1;
          sh_reg <= sh_next;
          if (bit_reg == 4'h0 && rxd) begin
            busy_reg <= 1'b0;
          end else if (bit_reg == last_bit) begin
            busy_reg <= 1'b0;
            strobe_reg <= 1'b1;
            ok_reg <= rxd;
            // Ninth bit or copy of bit seven
            word_reg <= len9 ? sh_next[8:0] :
                        {sh_next[8], sh_next[8:1]};
          end
        end
      end
    end
  end
  assign rx_word = word_reg;
  assign rx_strobe = strobe_reg;
  assign rx_frame_ok = ok_reg;
endmodule // asbd_rx

// ---- asbd_remote.sv ----
`timescale 1ns/1ps
// Far-side transceiver: decodes txd, drives rxd
module asbd_remote (
  input wire logic mclk,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic len9,
  input wire logic [15:0] bit_cyc,
  output logic rxd_in
);
  logic [8:0] got_word;
  logic got_stop;
  logic line_reg = 1'b1;
  int got_count;
  assign rxd_in = line_reg;
  initial begin
    got_word = 9'h000;
    got_stop = 1'b0;
    got_count = 0;
    forever begin
      @(posedge mclk);
      if (txd_oe === 1'b1 && txd_out === 1'b0) begin
        repeat (bit_cyc / 2) @(posedge mclk);
        got_word = 9'h000;
        for (int i = 0; i < (len9 ? 9 : 8); i++) begin
          repeat (bit_cyc) @(posedge mclk);
          got_word[i] = txd_out;
        end
        repeat (bit_cyc) @(posedge mclk);
        got_stop = txd_out;
        got_count++;
      end
    end
  end
  // One frame, first bit first; caller picks the stop level
  task automatic send(input logic [8:0] w, input logic stop);
    logic [10:0] f;
    f = len9 ? {stop, w, 1'b0} : {1'b0, stop, w[7:0], 1'b0};
    for (int i = 0; i < (len9 ? 11 : 10); i++) begin
      line_reg <= f[i];
      repeat (bit_cyc) @(posedge mclk);
    end
    line_reg <= 1'b1;
  endtask
endmodule // asbd_remote

// ---- async_serial_framing_baud_tb.sv ----
`timescale 1ns/1ps
module async_serial_framing_baud_tb;
  localparam logic [3:0] a_st = asbd_pkg::ADDR_STAT1;
  localparam logic [3:0] a_dt = asbd_pkg::ADDR_DATA;
  localparam logic [3:0] a_c1 = asbd_pkg::ADDR_CTRL1;
  localparam logic [3:0] a_c2 = asbd_pkg::ADDR_CTRL2;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic oscillator_clock = 1'b0;
  logic rxd_in;
  logic txd_out;
  logic txd_oe;
  logic tx_irq;
  logic len9 = 1'b0;
  logic [15:0] bit_cyc = 16'h0010;
  logic [1:0] osc_cnt = 2'h0;
  logic [31:0] q;
  logic [7:0] rv [2] = '{8'h81, 8'h7E};
  int fail_count = 0;
  int check_count = 0;
  int nframes = 0;
  int pre;
  int low;

  always #10 mclk = ~mclk;
  // Oscillator source with a period of six bus cycles
  always @(posedge mclk) begin
    osc_cnt <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
    if (osc_cnt == 2'h2) oscillator_clock <= ~oscillator_clock;
  end

  asbd_top asbd_top_i (.mclk(mclk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .oscillator_clock(oscillator_clock), .rxd_in(rxd_in),
    .txd_out(txd_out), .txd_oe(txd_oe), .tx_irq(tx_irq));
  asbd_remote asbd_remote_i (.mclk(mclk), .txd_out(txd_out),
    .txd_oe(txd_oe), .len9(len9), .bit_cyc(bit_cyc), .rxd_in(rxd_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic timed_out();
    fail_count++;
    $display("MISMATCH t=%0t wait limit reached", $time);
    end_of_test();
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
      input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (avs_waitrequest !== 1'b0) timed_out();
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait2();
    repeat (2) @(posedge mclk);
  endtask

  // Waits for the line to go low, then counts the low cycles
  task automatic low_run();
    pre = 0;
    low = 0;
    while (txd_out !== 1'b0 && pre < 60000) begin
      @(posedge mclk);
      pre++;
    end
    if (pre >= 60000) timed_out();
    while (txd_out === 1'b0 && low < 60000) begin
      @(posedge mclk);
      low++;
    end
    if (low >= 60000) timed_out();
  endtask

  // Status read arms the buffer, then the data write
  task automatic tx(input logic [7:0] d);
    bus(1'b0, a_st, 8'h00);
    bus(1'b1, a_dt, d);
    low_run();
  endtask

  task automatic wait_frame(input logic [8:0] w);
    int n;
    n = 0;
    nframes++;
    while (asbd_remote_i.got_count < nframes && n < 60000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 60000) timed_out();
    check(asbd_remote_i.got_stop, 1'b1);
    check(asbd_remote_i.got_word, w);
  endtask

  task automatic poll(input int b);
    int n;
    n = 0;
    q = 32'h00000000;
    while (q[b] !== 1'b1 && n < 3000) begin
      bus(1'b0, a_st, 8'h00);
      n++;
    end
    if (n >= 3000) timed_out();
  endtask

  task automatic baud_case(input logic [7:0] br, input int bit_n);
    bus(1'b1, asbd_pkg::ADDR_BAUD, br);
    bus(1'b0, asbd_pkg::ADDR_BAUD, 8'h00);
    check(q, {24'h000000, br});
    bit_cyc <= bit_n[15:0];
    // Second low run is bit one, whole and tick aligned
    tx(8'hFD);
    low_run();
    check(low, bit_n);
    wait_frame(9'h0FD);
    poll(asbd_pkg::S1_TDONE);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check(txd_out, 1'b1);
    check(txd_oe, 1'b0);
    check(tx_irq, 1'b0);
    bus(1'b0, a_c1, 8'h00);
    check(q, {24'h000000, asbd_pkg::RESET_CTRL});
    bus(1'b1, 4'hF, 8'hFF);
    bus(1'b0, 4'hF, 8'h00);
    check(q, 32'h00000000);
    bus(1'b1, a_c1, 8'h40);
    bus(1'b1, a_c2, 8'h0C);
    wait2();
    check(txd_oe, 1'b1);
    tx(8'hA5);
    check(pre >= 16, 1'b1);
    bus(1'b0, a_st, 8'h00);
    check(q[7:6], 2'b10);
    bus(1'b0, a_dt, 8'h00);
    check(q, 32'h00000000);
    wait_frame(9'h0A5);
    poll(asbd_pkg::S1_TDONE);
    check(q[7], 1'b1);
    check(tx_irq, 1'b0);
    bus(1'b1, a_c2, 8'h8C);
    wait2();
    check(tx_irq, 1'b1);
    bus(1'b1, a_c2, 8'h4C);
    wait2();
    check(tx_irq, 1'b1);
    bus(1'b1, a_c1, 8'h50);
    bus(1'b1, asbd_pkg::ADDR_CTRL3, 8'h40);
    len9 <= 1'b1;
    tx(8'h3C);
    check(tx_irq, 1'b0);
    wait_frame(9'h13C);
    poll(asbd_pkg::S1_TDONE);
    wait2();
    check(tx_irq, 1'b1);
    bus(1'b1, a_c2, 8'h0C);
    wait2();
    check(tx_irq, 1'b0);
    asbd_remote_i.send(9'h155, 1'b1);
    poll(asbd_pkg::S1_RFULL);
    bus(1'b0, a_dt, 8'h00);
    check(q, 32'h00000055);
    bus(1'b0, a_c2, 8'h00);
    check(q[0], 1'b1);
    bus(1'b1, a_c1, 8'h40);
    len9 <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      asbd_remote_i.send({1'b0, rv[i]}, 1'b1);
      poll(asbd_pkg::S1_RFULL);
      bus(1'b0, a_dt, 8'h00);
      check(q, {24'h000000, rv[i]});
      bus(1'b0, a_c2, 8'h00);
      check(q[0], rv[i][7]);
    end
    asbd_remote_i.send(9'h011, 1'b0);
    poll(asbd_pkg::S1_FERR);
    check(q[1], 1'b1);
    for (int c = 0; c < 6; c++) begin
      baud_case({5'h00, c[2:0]}, 16 << c);
    end
    baud_case(8'h11, 96);
    baud_case(8'h40, 96);
    // Idle queued by toggling the transmitter, re-set at once
    bus(1'b1, a_c2, 8'h04);
    bus(1'b1, a_c2, 8'h0C);
    tx(8'h5A);
    check(pre >= 96, 1'b1);
    wait_frame(9'h05A);
    poll(asbd_pkg::S1_TDONE);
    tx(8'hF0);
    bus(1'b1, a_c1, 8'h00);
    wait2();
    check(txd_oe, 1'b0);
    end_of_test();
  end
endmodule // async_serial_framing_baud_tb
